// [inc/pcs_defines.svh]
// constants of the program counter sequencer
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH
`define PCS_PC_W 14
`define PCS_INSTR_W 16
`define PCS_ROM_WORDS 12288
`define PCS_INSTR_BASE 10240
`define PCS_INSTR_STEP 256
`define PCS_TBL_STEP 512
`define PCS_SPLIT_MAX 8
`define PCS_SPLIT_N 4
`define PCS_PAGE_BIT 11
`define PCS_BANK_HI 13
`define PCS_BANK_LO 12
`define PCS_REL_W 11
`define PCS_PAGE_WORDS 2048
`define PCS_BANK_WORDS 4096
`define PCS_STACK_DEPTH 8
`define PCS_IDX_W 12
`define PCS_NIB_W 4
`define PCS_BYTE_W 8
`define PCS_VEC_RESET 14'h0000
`define PCS_VEC_EXT 14'h0010
`define PCS_VEC_PORTCD 14'h0014
`define PCS_VEC_TMR1 14'h0018
`define PCS_VEC_PREDIV 14'h001C
`define PCS_VEC_TMR2 14'h0020
`define PCS_VEC_KEYSCAN 14'h0024
`define PCS_VEC_FREQ 14'h0028
`endif

// [inc/pcs_pkg.sv]
// types shared by the program counter sequencer
`include "pcs_defines.svh"
package pcs_pkg;
  typedef enum logic [2:0] {op_next, op_absolute_jump, op_call, op_rel_jump, op_return, op_hold} pcs_op_t;
  typedef enum logic [2:0] {irq_ext, irq_portcd, irq_tmr1, irq_prediv, irq_tmr2, irq_keyscan, irq_freq} pcs_irq_src_t;
  typedef enum logic [1:0] {nib_low, nib_high, nib_upper} pcs_nib_sel_t;
  typedef struct packed {
    logic valid;
    pcs_op_t op;
    logic [`PCS_PC_W-1:0] target;
  } pcs_cmd_t;
  typedef struct packed {
    logic take;
    pcs_irq_src_t src;
  } pcs_irq_t;
  typedef struct packed {
    logic we;
    pcs_nib_sel_t sel;
    logic [`PCS_NIB_W-1:0] data;
  } pcs_idx_wr_t;
  typedef struct packed {
    logic req;
    logic nib_hi;
  } pcs_tbl_rd_t;
  function automatic logic [`PCS_PC_W-1:0] pcs_vector(input pcs_irq_src_t src);
    case (src)
      irq_ext: return `PCS_VEC_EXT;
      irq_portcd: return `PCS_VEC_PORTCD;
      irq_tmr1: return `PCS_VEC_TMR1;
      irq_prediv: return `PCS_VEC_PREDIV;
      irq_tmr2: return `PCS_VEC_TMR2;
      irq_keyscan: return `PCS_VEC_KEYSCAN;
      irq_freq: return `PCS_VEC_FREQ;
      default: return `PCS_VEC_RESET;
    endcase
  endfunction
endpackage

// [rtl/pcs_stack.sv]
// eight-level return stack with wrapping pointer
`timescale 1ns/1ps
`include "pcs_defines.svh"
module pcs_stack
  import pcs_pkg::*;
#(
  parameter int DEPTH = `PCS_STACK_DEPTH,
  parameter int WIDTH = `PCS_PC_W
)(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [WIDTH-1:0] push_data_i,
  output logic [WIDTH-1:0] top_o,
  output logic [$clog2(DEPTH)-1:0] sp_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] sp_r;
  logic [PW-1:0] sp_nxt;

  // depth must be a power of two: wrap comes from plain pointer overflow
  always_comb
  begin
    sp_nxt = sp_r;
    if (push_i)
      sp_nxt = sp_r + 1'b1;
    else if (pop_i)
      sp_nxt = sp_r - 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      sp_r <= PW'(DEPTH - 1);
    else
      sp_r <= sp_nxt;
  end

  always_ff @(posedge clock_i)
  begin
    if (push_i && !rst_i)
      mem_r[sp_nxt] <= push_data_i;
  end

  assign top_o = mem_r[sp_r];
  assign sp_o = sp_r;
endmodule

// [rtl/pcs_rom.sv]
// shared instruction and table memory with split option
`timescale 1ns/1ps
`include "pcs_defines.svh"
module pcs_rom
  import pcs_pkg::*;
#(
  parameter int SPLIT_N = `PCS_SPLIT_N,
  parameter int WORDS = `PCS_ROM_WORDS
)(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [`PCS_PC_W-1:0] fetch_addr_i,
  input wire logic tbl_req_i,
  input wire logic [`PCS_IDX_W-1:0] tbl_addr_i,
  input wire logic tbl_nib_hi_i,
  input wire logic load_we_i,
  input wire logic [`PCS_PC_W-1:0] load_addr_i,
  input wire logic [`PCS_INSTR_W-1:0] load_data_i,
  output logic [`PCS_INSTR_W-1:0] instr_o,
  output logic instr_err_o,
  output logic [`PCS_BYTE_W-1:0] tbl_byte_o,
  output logic [`PCS_NIB_W-1:0] tbl_nibble_o,
  output logic tbl_err_o
);
  localparam int INSTR_WORDS = `PCS_INSTR_BASE + `PCS_INSTR_STEP * SPLIT_N;
  localparam int TBL_BYTES = `PCS_TBL_STEP * (`PCS_SPLIT_MAX - SPLIT_N);
  logic [`PCS_INSTR_W-1:0] mem [WORDS];
  logic [`PCS_INSTR_W-1:0] instr_r, instr_nxt, tword;
  logic [`PCS_BYTE_W-1:0] tbl_r, tbl_nxt;
  // nibble kept in its own register so the top output comes from a flop
  logic [`PCS_NIB_W-1:0] nib_r, nib_nxt;
  logic ierr_r, ierr_nxt, terr_r, terr_nxt, fetch_ok, tbl_ok;
  logic [`PCS_PC_W-1:0] tbl_word;

  // mask contents are loaded through this port before use
  always_ff @(posedge clock_i)
  begin
    if (load_we_i && int'(load_addr_i) < WORDS)
      mem[load_addr_i] <= load_data_i;
  end

  always_comb
  begin
    fetch_ok = int'(fetch_addr_i) < INSTR_WORDS;
    tbl_ok = int'(tbl_addr_i) < TBL_BYTES;
    tbl_word = `PCS_PC_W'(INSTR_WORDS + int'(tbl_addr_i[`PCS_IDX_W-1:1]));
    tword = tbl_ok ? mem[tbl_word] : '0;
    instr_nxt = fetch_ok ? mem[fetch_addr_i] : '0;
    ierr_nxt = !fetch_ok;
    tbl_nxt = tbl_r;
    nib_nxt = nib_r;
    terr_nxt = terr_r;
    if (tbl_req_i)
    begin
      tbl_nxt = tbl_addr_i[0] ? tword[15:8] : tword[7:0];
      nib_nxt = tbl_nib_hi_i ? tbl_nxt[7:4] : tbl_nxt[3:0];
      terr_nxt = !tbl_ok;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      instr_r <= '0;
      ierr_r <= 1'b0;
      tbl_r <= '0;
      nib_r <= '0;
      terr_r <= 1'b0;
    end
    else
    begin
      instr_r <= instr_nxt;
      ierr_r <= ierr_nxt;
      tbl_r <= tbl_nxt;
      nib_r <= nib_nxt;
      terr_r <= terr_nxt;
    end
  end

  assign instr_o = instr_r;
  assign instr_err_o = ierr_r;
  assign tbl_byte_o = tbl_r;
  assign tbl_nibble_o = nib_r;
  assign tbl_err_o = terr_r;
endmodule

// [rtl/pcs_top.sv]
// program counter sequencer: counter, vectors, stack, index pointer, table reads
// Operation
// - 14-bit counter addressing up to 12288 instruction words
// - counter bit 11 selects page half
// - absolute jump and call load fourteen bits
// - counter bits 13 and 12 select bank
// - sequential step adds one, carries freely
// - other jumps keep bits 13-11, replace low
// - reset loads 000h, interrupts load fixed vectors
// - call pushes counter plus one, interrupt pushes counter onto stack
// - return loads stack top, pointer decrements
// - memory is 12288 by 16, six pages
// - split option N divides instruction/table space
// - table entries read as 8-bit bytes
// - table address from index pointer, byte/nibble
// - large programs organised as pages and banks
// - stack holds eight 14-bit entries, no flag
// - overflow wraps to 0, underflow to 7
// - index pointer 12 bits, nibble-wise writes
`timescale 1ns/1ps
`include "pcs_defines.svh"
module pcs_top
  import pcs_pkg::*;
#(
  parameter int SPLIT_N = `PCS_SPLIT_N
)(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire pcs_cmd_t cmd_i,
  input wire pcs_irq_t irq_i,
  input wire pcs_idx_wr_t idx_wr_i,
  input wire pcs_tbl_rd_t tbl_rd_i,
  input wire logic load_we_i,
  input wire logic [`PCS_PC_W-1:0] load_addr_i,
  input wire logic [`PCS_INSTR_W-1:0] load_data_i,
  output logic [`PCS_PC_W-1:0] pc_o,
  output logic [`PCS_INSTR_W-1:0] instr_o,
  output logic instr_err_o,
  output logic [`PCS_BYTE_W-1:0] tbl_byte_o,
  output logic [`PCS_NIB_W-1:0] tbl_nibble_o,
  output logic tbl_valid_o,
  output logic tbl_err_o,
  output logic [2:0] stack_ptr_o,
  output logic page_o,
  output logic [1:0] bank_o,
  output logic paged_org_o,
  output logic banked_org_o
);
  localparam int INSTR_WORDS = `PCS_INSTR_BASE + `PCS_INSTR_STEP * SPLIT_N;
  localparam int TBL_BYTES = `PCS_TBL_STEP * (`PCS_SPLIT_MAX - SPLIT_N);

  logic [`PCS_PC_W-1:0] pc_r, pc_nxt, push_data, stk_top;
  logic [`PCS_IDX_W-1:0] idx_r, idx_nxt;
  logic tvalid_r, tvalid_nxt;
  logic paged_r, paged_nxt, banked_r, banked_nxt;
  logic push, pop, take, step;
  logic [2:0] sp;
  logic [`PCS_BYTE_W-1:0] tbl_byte;

  assign take = irq_i.take;
  assign step = cmd_i.valid && !take;

  // interrupt preempts the instruction of that cycle, so the counter
  // still names the next unexecuted instruction and is saved as-is
  always_comb
  begin
    pc_nxt = pc_r;
    push = 1'b0;
    pop = 1'b0;
    push_data = pc_r;
    if (take)
    begin
      pc_nxt = pcs_vector(irq_i.src);
      push = 1'b1;
    end
    else if (cmd_i.valid)
    begin
      case (cmd_i.op)
        op_next:
          pc_nxt = pc_r + 1'b1;
        op_absolute_jump:
          pc_nxt = cmd_i.target;
        op_call:
        begin
          pc_nxt = cmd_i.target;
          push = 1'b1;
          push_data = pc_r + 1'b1;
        end
        op_rel_jump:
          pc_nxt = {pc_r[`PCS_BANK_HI:`PCS_PAGE_BIT], cmd_i.target[`PCS_REL_W-1:0]};
        op_return:
        begin
          pc_nxt = stk_top;
          pop = 1'b1;
        end
        op_hold:
          pc_nxt = pc_r;
        default:
          pc_nxt = pc_r;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      pc_r <= `PCS_VEC_RESET;
    else
      pc_r <= pc_nxt;
  end

  // index pointer is write-only from the instruction side
  always_comb
  begin
    idx_nxt = idx_r;
    if (idx_wr_i.we)
    begin
      case (idx_wr_i.sel)
        nib_low: idx_nxt[3:0] = idx_wr_i.data;
        nib_high: idx_nxt[7:4] = idx_wr_i.data;
        nib_upper: idx_nxt[11:8] = idx_wr_i.data;
        default: idx_nxt = idx_r;
      endcase
    end
  end

  always_comb
  begin
    tvalid_nxt = tbl_rd_i.req;
    paged_nxt = INSTR_WORDS > `PCS_PAGE_WORDS;
    banked_nxt = INSTR_WORDS > `PCS_BANK_WORDS;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      idx_r <= '0;
      tvalid_r <= 1'b0;
      paged_r <= 1'b0;
      banked_r <= 1'b0;
    end
    else
    begin
      idx_r <= idx_nxt;
      tvalid_r <= tvalid_nxt;
      paged_r <= paged_nxt;
      banked_r <= banked_nxt;
    end
  end

  pcs_stack #(
    .DEPTH(`PCS_STACK_DEPTH),
    .WIDTH(`PCS_PC_W)
  ) u_stack (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .push_i(push),
    .pop_i(pop),
    .push_data_i(push_data),
    .top_o(stk_top),
    .sp_o(sp)
  );

  // fetch uses the next counter so the word lines up with pc_o
  pcs_rom #(
    .SPLIT_N(SPLIT_N),
    .WORDS(`PCS_ROM_WORDS)
  ) u_rom (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .fetch_addr_i(rst_i ? `PCS_VEC_RESET : pc_nxt),
    .tbl_req_i(tbl_rd_i.req),
    .tbl_addr_i(idx_r),
    .tbl_nib_hi_i(tbl_rd_i.nib_hi),
    .load_we_i(load_we_i),
    .load_addr_i(load_addr_i),
    .load_data_i(load_data_i),
    .instr_o(instr_o),
    .instr_err_o(instr_err_o),
    .tbl_byte_o(tbl_byte),
    .tbl_nibble_o(tbl_nibble_o),
    .tbl_err_o(tbl_err_o)
  );

  assign pc_o = pc_r;
  assign tbl_byte_o = tbl_byte;
  assign tbl_valid_o = tvalid_r;
  assign stack_ptr_o = sp;
  assign page_o = pc_r[`PCS_PAGE_BIT];
  assign bank_o = pc_r[`PCS_BANK_HI:`PCS_BANK_LO];
  assign paged_org_o = paged_r;
  assign banked_org_o = banked_r;

  // checks
  logic is_seq, is_abs, is_call, is_rel, is_ret, idle;
  logic [`PCS_PC_W-1:0] tgt, vec;
  assign tgt = cmd_i.target;
  // expected vectors kept apart from the lookup that the counter uses
  always_comb
  begin
    case (irq_i.src)
      irq_ext: vec = `PCS_VEC_EXT;
      irq_portcd: vec = `PCS_VEC_PORTCD;
      irq_tmr1: vec = `PCS_VEC_TMR1;
      irq_prediv: vec = `PCS_VEC_PREDIV;
      irq_tmr2: vec = `PCS_VEC_TMR2;
      irq_keyscan: vec = `PCS_VEC_KEYSCAN;
      irq_freq: vec = `PCS_VEC_FREQ;
      default: vec = `PCS_VEC_RESET;
    endcase
  end
  assign is_seq = step && cmd_i.op == op_next;
  assign is_abs = step && cmd_i.op == op_absolute_jump;
  assign is_call = step && cmd_i.op == op_call;
  assign is_rel = step && cmd_i.op == op_rel_jump;
  assign is_ret = step && cmd_i.op == op_return;
  assign idle = !take && (!cmd_i.valid || cmd_i.op == op_hold);

  // eight pushes in a row must bring the pointer back to where the run began
  logic [3:0] run_cnt_r, run_cnt_nxt;
  logic [2:0] run_sp_r, run_sp_nxt;

  always_comb
  begin
    run_cnt_nxt = run_cnt_r;
    run_sp_nxt = run_sp_r;
    if (pop)
      run_cnt_nxt = 4'h0;
    else if (push)
    begin
      if (run_cnt_r == 4'h0 || run_cnt_r == 4'h8)
      begin
        run_cnt_nxt = 4'h1;
        run_sp_nxt = sp;
      end
      else
        run_cnt_nxt = run_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      run_cnt_r <= 4'h0;
      run_sp_r <= 3'h0;
    end
    else
    begin
      run_cnt_r <= run_cnt_nxt;
      run_sp_r <= run_sp_nxt;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  reset_vector_a: assert property ($fell(rst_i) |-> pc_r == `PCS_VEC_RESET && sp == 3'h7)
    else $error("counter not at reset vector after reset");
  irq_vector_a: assert property (take |=> pc_r == $past(vec))
    else $error("interrupt did not load its vector");
  irq_push_a: assert property (take |=> stk_top == $past(pc_r) && sp == $past(sp) + 3'h1)
    else $error("interrupt did not save the counter");
  call_jump_a: assert property (is_call |=> pc_r == $past(tgt) && stk_top == $past(pc_r) + 14'h0001)
    else $error("call target or saved return wrong");
  abs_jump_a: assert property (is_abs |=> pc_r == $past(tgt) && sp == $past(sp))
    else $error("absolute jump target wrong");
  rel_jump_a: assert property (is_rel |=> pc_r[13:11] == $past(pc_r[13:11]) && pc_r[10:0] == $past(tgt[10:0]))
    else $error("relative jump left its page");
  seq_step_a: assert property (is_seq |=> pc_r == $past(pc_r) + 14'h0001)
    else $error("sequential step not plus one");
  return_pop_a: assert property (is_ret |=> pc_r == $past(stk_top) && sp == $past(sp) - 3'h1)
    else $error("return did not restore and decrement");
  stack_wrap_a: assert property ((push && sp == 3'h7) |=> sp == 3'h0)
    else $error("stack overflow did not wrap to level 0");
  idle_hold_a: assert property (idle |=> $stable(pc_r))
    else $error("counter moved without an instruction");
  table_read_a: assert property (tbl_rd_i.req |=> tbl_valid_o)
    else $error("table read not answered");
  table_nib_a: assert property (tbl_rd_i.req && !tbl_rd_i.nib_hi |=> tbl_nibble_o == tbl_byte_o[3:0])
    else $error("low nibble select wrong");
  table_idle_a: assert property (!tbl_rd_i.req |=> !tbl_valid_o)
    else $error("table valid without a request");
  table_hi_a: assert property (tbl_rd_i.req && tbl_rd_i.nib_hi |=> tbl_nibble_o == tbl_byte_o[7:4])
    else $error("high nibble select wrong");
  table_err_a: assert property (tbl_rd_i.req |=> tbl_err_o == (int'($past(idx_r)) >= TBL_BYTES))
    else $error("table range flag wrong");
  table_hold_a: assert property (!tbl_rd_i.req |=> $stable(tbl_byte_o) && $stable(tbl_nibble_o))
    else $error("table data moved without a request");
  stack_under_a: assert property ((pop && sp == 3'h0) |=> sp == 3'h7)
    else $error("stack underflow did not wrap to level 7");
  stack_depth_a: assert property (run_cnt_r == 4'h8 |-> sp == run_sp_r)
    else $error("eight pushes did not wrap the stack");
  fetch_err_a: assert property (instr_err_o == (int'(pc_r) >= INSTR_WORDS))
    else $error("fetch range flag wrong");
  idx_low_a: assert property (idx_wr_i.we && idx_wr_i.sel == nib_low |=> idx_r[3:0] == $past(idx_wr_i.data))
    else $error("index low nibble not written");
  idx_high_a: assert property (idx_wr_i.we && idx_wr_i.sel == nib_high |=> idx_r[7:4] == $past(idx_wr_i.data))
    else $error("index high nibble not written");
  idx_upper_a: assert property (idx_wr_i.we && idx_wr_i.sel == nib_upper |=> idx_r[11:8] == $past(idx_wr_i.data))
    else $error("index upper nibble not written");
  org_flags_a: assert property (!$past(rst_i) |-> paged_org_o == (INSTR_WORDS > `PCS_PAGE_WORDS)
    && banked_org_o == (INSTR_WORDS > `PCS_BANK_WORDS))
    else $error("organisation flags wrong");
  irq_drop_a: assert property (take && cmd_i.valid |=> pc_r == $past(vec) && sp == $past(sp) + 3'h1)
    else $error("instruction not dropped under interrupt");
  abs_bank_a: assert property (is_abs |=> bank_o == $past(tgt[13:12]))
    else $error("absolute jump did not set the bank");
  rel_page_a: assert property (is_rel |=> page_o == $past(page_o) && bank_o == $past(bank_o))
    else $error("relative jump changed page or bank");

  call_c: cover property (is_call ##[1:20] is_ret);
  overflow_c: cover property (push && sp == 3'h7);
  underflow_c: cover property (pop && sp == 3'h0);
  irq_c: cover property (take && cmd_i.valid);
  table_c: cover property (idx_wr_i.we ##1 tbl_rd_i.req);
endmodule

// [tb/pcs_rom_model.sv]
// mask content loader standing in for the factory-programmed array
`timescale 1ns/1ps
`include "pcs_defines.svh"
module pcs_rom_model
#(
  parameter int WORDS = `PCS_ROM_WORDS
)(
  input wire logic clock_i,
  output logic load_we_o,
  output logic [`PCS_PC_W-1:0] load_addr_o,
  output logic [`PCS_INSTR_W-1:0] load_data_o,
  output logic done_o
);
  // high byte differs per address, low byte per 64 addresses, so a swapped byte lane shows
  function automatic logic [15:0] pat(input logic [13:0] a);
    return {a[7:0] ^ 8'h5A, a[13:6]};
  endfunction

  initial
  begin
    load_we_o = 1'b0;
    load_addr_o = 14'h0000;
    load_data_o = 16'h0000;
    done_o = 1'b0;
    for (int a = 0; a < WORDS; a++)
    begin
      @(posedge clock_i);
      #2;
      load_we_o = 1'b1;
      load_addr_o = 14'(a);
      load_data_o = pat(14'(a));
    end
    @(posedge clock_i);
    #2;
    load_we_o = 1'b0;
    // released port shows no stale word
    load_data_o = ~load_data_o;
    done_o = 1'b1;
  end
endmodule

// [tb/pcs_top_tb_top.sv]
// self-checking bench for the program counter sequencer
`timescale 1ns/1ps
`include "pcs_defines.svh"
module pcs_top_tb_top;
  import pcs_pkg::*;
  localparam int SPLIT = 4;
  localparam int ISZ = `PCS_INSTR_BASE + `PCS_INSTR_STEP * SPLIT;
  localparam int TSZ = `PCS_TBL_STEP * (`PCS_SPLIT_MAX - SPLIT);
  typedef struct packed {pcs_op_t op; logic [13:0] tgt; logic [13:0] pc;} pcs_row_t;
  logic clock_i;
  logic rst_i;
  pcs_cmd_t cmd_i;
  pcs_irq_t irq_i;
  pcs_idx_wr_t idx_wr_i;
  pcs_tbl_rd_t tbl_rd_i;
  logic load_we_i;
  logic [13:0] load_addr_i;
  logic [15:0] load_data_i;
  logic ld_done;
  logic [13:0] pc_o;
  logic [15:0] instr_o;
  logic instr_err_o;
  logic [7:0] tbl_byte_o;
  logic [3:0] tbl_nibble_o;
  logic tbl_valid_o;
  logic tbl_err_o;
  logic [2:0] stack_ptr_o;
  logic page_o;
  logic [1:0] bank_o;
  logic paged_org_o;
  logic banked_org_o;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [13:0] epc;
  logic [2:0] esp;
  logic [13:0] stk [8];
  pcs_row_t rows [11];

  pcs_top #(.SPLIT_N(SPLIT)) u_pcs_top (.clock_i(clock_i), .rst_i(rst_i), .cmd_i(cmd_i), .irq_i(irq_i),
    .idx_wr_i(idx_wr_i), .tbl_rd_i(tbl_rd_i), .load_we_i(load_we_i), .load_addr_i(load_addr_i),
    .load_data_i(load_data_i), .pc_o(pc_o), .instr_o(instr_o), .instr_err_o(instr_err_o),
    .tbl_byte_o(tbl_byte_o), .tbl_nibble_o(tbl_nibble_o), .tbl_valid_o(tbl_valid_o), .tbl_err_o(tbl_err_o),
    .stack_ptr_o(stack_ptr_o), .page_o(page_o), .bank_o(bank_o), .paged_org_o(paged_org_o),
    .banked_org_o(banked_org_o));

  pcs_rom_model u_pcs_rom_model (.clock_i(clock_i), .load_we_o(load_we_i), .load_addr_o(load_addr_i),
    .load_data_o(load_data_i), .done_o(ld_done));

  initial
  begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // generous ceiling: the content load alone takes about 12300 cycles
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      complete_run;
    end
  end

  // same word pattern as the content loader writes
  function automatic logic [15:0] pat(input logic [13:0] a);
    return {a[7:0] ^ 8'h5A, a[13:6]};
  endfunction

  // one instruction or interrupt per call, inputs held into the next call
  task step(input pcs_op_t op, input logic [13:0] tgt, input logic tk, input pcs_irq_src_t src);
    cmd_i = '{1'b1, op, tgt};
    irq_i = '{tk, src};
    if (tk)
    begin
      esp++;
      stk[esp] = epc;
      epc = 14'h0010 + {9'h000, src, 2'b00};
    end
    else
      case (op)
        op_next: epc = epc + 14'h0001;
        op_absolute_jump: epc = tgt;
        op_call:
        begin
          esp++;
          stk[esp] = epc + 14'h0001;
          epc = tgt;
        end
        op_rel_jump: epc = {epc[13:11], tgt[10:0]};
        op_return:
        begin
          epc = stk[esp];
          esp--;
        end
        default: epc = epc;
      endcase
    @(posedge clock_i);
    #2;
    chk(pc_o, epc);
    chk(stack_ptr_o, esp);
    chk(page_o, epc[11]);
    chk(bank_o, epc[13:12]);
    chk(instr_o, epc < ISZ ? pat(epc) : 16'h0000);
    chk(instr_err_o, epc >= ISZ);
  endtask

  task idle;
    cmd_i.valid = 1'b0;
    irq_i.take = 1'b0;
  endtask

  task tbl_read(input logic [11:0] b, input logic hi);
    logic [15:0] w;
    logic [7:0] eb;
    w = pat(14'(ISZ + int'(b >> 1)));
    eb = (b >= TSZ) ? 8'h00 : (b[0] ? w[15:8] : w[7:0]);
    for (int k = 0; k < 3; k++)
    begin
      idx_wr_i = '{1'b1, pcs_nib_sel_t'(k), b[4*k +: 4]};
      @(posedge clock_i);
      #2;
    end
    idx_wr_i.we = 1'b0;
    tbl_rd_i = '{1'b1, hi};
    @(posedge clock_i);
    #2;
    tbl_rd_i.req = 1'b0;
    chk(tbl_valid_o, 1'b1);
    chk(tbl_byte_o, eb);
    chk(tbl_nibble_o, hi ? eb[7:4] : eb[3:0]);
    chk(tbl_err_o, b >= TSZ);
    @(posedge clock_i);
    #2;
    chk(tbl_valid_o, 1'b0);
    chk(tbl_byte_o, eb);
  endtask

  initial
  begin
    rst_i = 1'b1;
    cmd_i = '0;
    irq_i = '0;
    idx_wr_i = '0;
    tbl_rd_i = '0;
    epc = 14'h0000;
    esp = 3'h7;
    rows[0] = '{op_next, 14'h0000, 14'h0001};
    rows[1] = '{op_absolute_jump, 14'h07FF, 14'h07FF};
    rows[2] = '{op_next, 14'h0000, 14'h0800};
    rows[3] = '{op_rel_jump, 14'h0123, 14'h0923};
    rows[4] = '{op_absolute_jump, 14'h1FFF, 14'h1FFF};
    rows[5] = '{op_next, 14'h0000, 14'h2000};
    rows[6] = '{op_rel_jump, 14'h07FF, 14'h27FF};
    rows[7] = '{op_absolute_jump, 14'h2BFF, 14'h2BFF};
    rows[8] = '{op_next, 14'h0000, 14'h2C00};
    rows[9] = '{op_hold, 14'h1234, 14'h2C00};
    rows[10] = '{op_rel_jump, 14'h3FFF, 14'h2FFF};
    repeat (4) @(posedge clock_i);
    #2;
    chk(pc_o, 14'h0000);
    chk(stack_ptr_o, 3'h7);
    chk(paged_org_o, 1'b0);
    chk(banked_org_o, 1'b0);
    rst_i = 1'b0;
    while (!ld_done) @(posedge clock_i);
    #2;
    chk(paged_org_o, ISZ > `PCS_PAGE_WORDS);
    chk(banked_org_o, ISZ > `PCS_BANK_WORDS);
    $display("reset and load test done");
    foreach (rows[i])
    begin
      step(rows[i].op, rows[i].tgt, 1'b0, irq_ext);
      chk(pc_o, rows[i].pc);
    end
    idle;
    $display("jump table test done");
    // each interrupt arrives with a call that must be lost
    for (int i = 0; i < 7; i++)
      step(op_call, 14'h0555, 1'b1, pcs_irq_src_t'(i));
    step(op_call, 14'h0300, 1'b0, irq_ext);
    step(op_call, 14'h0400, 1'b0, irq_ext);
    repeat (10) step(op_return, 14'h0000, 1'b0, irq_ext);
    idle;
    $display("interrupt and stack test done");
    tbl_read(12'h000, 1'b0);
    tbl_read(12'h001, 1'b1);
    tbl_read(12'(TSZ - 1), 1'b0);
    tbl_read(12'(TSZ), 1'b1);
    $display("table test done");
    irq_i = '{1'b1, irq_freq};
    rst_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #2;
    chk(pc_o, 14'h0000);
    chk(stack_ptr_o, 3'h7);
    chk(tbl_valid_o, 1'b0);
    rst_i = 1'b0;
    epc = 14'h0000;
    esp = 3'h7;
    step(op_next, 14'h0000, 1'b0, irq_ext);
    idle;
    $display("second reset test done");
    complete_run;
  end
endmodule
